// file: verilog/dac_pkg.sv
// Overview of operation
// - After reset use automatic offset, primary antenna front, secondary rear.
// - With manual offset type, ignore the orientation byte of the packet.
// - With automatic offset type, ignore the three manual offsets of the packet.
// - In automatic mode, computed offsets overwrite the stored X, Y, Z offsets.
// - Antenna packet is id 196, 17 payload bytes, byte 0 persistence.
// - Bytes 1-2 offset type (0 manual, 1 auto); X, Y, Z at 5, 9, 13.
// - Byte 3 orientation selector; byte 4 reserved, written as zero.
// - Orientation 0 F/R, 1 R/F, 2 right/left, 3 left/right.
// - Id 198 stores 64 opaque user bytes, returned unchanged, never used.
// - Id 199, 65 bytes: persistence, fp32 gimbal scale, 60 reserved.
package dac_pkg;
   localparam logic [7:0] ID_ANT = 8'hc4;
   localparam logic [7:0] ID_USER = 8'hc6;
   localparam logic [7:0] ID_GPIO = 8'hc7;
   localparam logic [7:0] LEN_ANT = 8'h11;
   localparam logic [7:0] LEN_USER = 8'h40;
   localparam logic [7:0] LEN_GPIO = 8'h41;
   localparam int BUF_DEPTH = 65;
   localparam int USER_BYTES = 64;
   localparam int B_PERM = 0;
   localparam int B_OTYPE = 1;
   localparam int B_ORIENT = 3;
   localparam int B_RSVD = 4;
   localparam int B_OFS_X = 5;
   localparam int B_OFS_Y = 9;
   localparam int B_OFS_Z = 13;
   localparam int B_GIMBAL = 1;
   localparam logic [15:0] OTYPE_MANUAL = 16'h0000;
   localparam logic [15:0] OTYPE_AUTO = 16'h0001;
   localparam logic [7:0] ORI_MAX = 8'h03;
   localparam logic [1:0] ORI_PF_SR = 2'h0;
   localparam logic [1:0] ORI_PR_SF = 2'h1;
   localparam logic [1:0] ORI_PRT_SLT = 2'h2;
   localparam logic [1:0] ORI_PLT_SRT = 2'h3;
   localparam logic [1:0] POS_FRONT = 2'h0;
   localparam logic [1:0] POS_REAR = 2'h1;
   localparam logic [1:0] POS_RIGHT = 2'h2;
   localparam logic [1:0] POS_LEFT = 2'h3;
   // AXI4-Lite register byte addresses
   localparam logic [7:0] REG_ANT_CFG = 8'h00;
   localparam logic [7:0] REG_OFS_X = 8'h04;
   localparam logic [7:0] REG_OFS_Y = 8'h08;
   localparam logic [7:0] REG_OFS_Z = 8'h0c;
   localparam logic [7:0] REG_GIMBAL = 8'h10;
   localparam logic [7:0] REG_GPIO_CFG = 8'h14;
   localparam logic [7:0] REG_PKT_STAT = 8'h18;
   localparam logic [7:0] REG_CTRL = 8'h1c;
   localparam logic [1:0] USER_REGION = 2'h1;
   localparam int F_AUTO = 0;
   localparam int F_CALC = 1;
   localparam int F_ORI_LSB = 8;
   localparam int F_PRIM_LSB = 12;
   localparam int F_SEC_LSB = 14;
   localparam int F_PERM = 16;
   localparam int F_OK_LSB = 0;
   localparam int F_BAD_LSB = 8;
   localparam int F_BADID_LSB = 16;
   localparam int F_EN = 0;
   localparam int F_CLR = 1;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: verilog/dac_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module dac_decoder
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic pkt_start,
   input wire logic [7:0] pkt_id,
   input wire logic [7:0] pkt_len,
   input wire logic pkt_byte_valid,
   input wire logic [7:0] pkt_byte,
   input wire logic pkt_end,
   input wire logic calc_valid,
   input wire logic [31:0] calc_x,
   input wire logic [31:0] calc_y,
   input wire logic [31:0] calc_z,
   input wire logic rd_req,
   input wire logic [7:0] rd_id,
   output logic rd_busy,
   output logic rply_valid,
   output logic [7:0] rply_byte,
   output logic rply_last,
   input wire logic rply_ready,
   output logic auto_mode,
   output logic [1:0] prim_pos,
   output logic [1:0] sec_pos,
   output logic [31:0] ofs_x,
   output logic [31:0] ofs_y,
   output logic [31:0] ofs_z,
   output logic [31:0] gimbal_scale,
   output logic cfg_update,
   output logic persist_req,
   output logic [7:0] persist_id,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef enum logic [1:0] {DAC_IDLE, DAC_RECV} dac_rx_t;
   typedef enum logic [1:0] {DAC_TX_IDLE, DAC_TX_SEND} dac_tx_t;
   typedef logic [dac_pkg::BUF_DEPTH-1:0][7:0] dac_stage_t;

   typedef struct packed {
      dac_rx_t rx;
      logic [7:0] id;
      logic [7:0] len;
      logic [6:0] cnt;
      logic ovf;
      dac_stage_t stage;
      logic auto_mode;
      logic calc_seen;
      logic [1:0] orient;
      logic [1:0] prim;
      logic [1:0] sec;
      logic [31:0] ofs_x;
      logic [31:0] ofs_y;
      logic [31:0] ofs_z;
      logic [31:0] gimbal;
      logic ant_perm;
      logic gpio_perm;
      logic [dac_pkg::USER_BYTES-1:0][7:0] user;
      logic [7:0] n_ok;
      logic [7:0] n_bad;
      logic [7:0] bad_id;
      logic en;
      logic upd;
      logic persist;
      logic [7:0] persist_id;
      dac_tx_t tx;
      logic [7:0] tx_id;
      logic [6:0] tx_idx;
      logic [6:0] tx_len;
      logic [7:0] tx_byte;
      logic aw_got;
      logic [7:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } dac_state_t;

   dac_state_t s_r;
   dac_state_t s_nxt;
   logic [31:0] rd_val;
   logic rd_hit;

   function automatic logic [31:0] get32(input dac_stage_t st, input int i);
      get32 = {st[i+3], st[i+2], st[i+1], st[i]};
   endfunction

   function automatic logic [3:0] pos_of(input logic [1:0] ori);
      case (ori)
         dac_pkg::ORI_PF_SR: pos_of = {dac_pkg::POS_FRONT, dac_pkg::POS_REAR};
         dac_pkg::ORI_PR_SF: pos_of = {dac_pkg::POS_REAR, dac_pkg::POS_FRONT};
         dac_pkg::ORI_PRT_SLT: pos_of = {dac_pkg::POS_RIGHT, dac_pkg::POS_LEFT};
         default: pos_of = {dac_pkg::POS_LEFT, dac_pkg::POS_RIGHT};
      endcase
   endfunction

   function automatic logic [7:0] exp_len(input logic [7:0] id);
      case (id)
         dac_pkg::ID_ANT: exp_len = dac_pkg::LEN_ANT;
         dac_pkg::ID_USER: exp_len = dac_pkg::LEN_USER;
         dac_pkg::ID_GPIO: exp_len = dac_pkg::LEN_GPIO;
         default: exp_len = 8'h00;
      endcase
   endfunction

   // Reply payload is rebuilt from the live settings, so a read of the
   // antenna packet in automatic mode returns the computed offsets.
   function automatic logic [7:0] tx_at(input dac_state_t s,
                                       input logic [6:0] i);
      logic [7:0] b;
      b = 8'h00;
      case (s.tx_id)
         dac_pkg::ID_ANT:
         begin
            if (i == 7'(dac_pkg::B_PERM))
               b = {7'h00, s.ant_perm};
            else if (i == 7'(dac_pkg::B_OTYPE))
               b = {7'h00, s.auto_mode};
            else if (i == 7'(dac_pkg::B_ORIENT))
               b = {6'h00, s.orient};
            else if (i >= 7'(dac_pkg::B_OFS_Z) && i < 7'(dac_pkg::LEN_ANT))
               b = s.ofs_z[8*(i-7'(dac_pkg::B_OFS_Z)) +: 8];
            else if (i >= 7'(dac_pkg::B_OFS_Y))
               b = s.ofs_y[8*(i-7'(dac_pkg::B_OFS_Y)) +: 8];
            else if (i >= 7'(dac_pkg::B_OFS_X))
               b = s.ofs_x[8*(i-7'(dac_pkg::B_OFS_X)) +: 8];
         end
         dac_pkg::ID_USER: b = s.user[i[5:0]];
         dac_pkg::ID_GPIO:
         begin
            if (i == 7'(dac_pkg::B_PERM))
               b = {7'h00, s.gpio_perm};
            else if (i < 7'(dac_pkg::B_GIMBAL + 4))
               b = s.gimbal[8*(i-7'(dac_pkg::B_GIMBAL)) +: 8];
         end
         default: b = 8'h00;
      endcase
      tx_at = b;
   endfunction

   always_comb
   begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      if (s_axi_araddr[7:6] == dac_pkg::USER_REGION)
         rd_val = {s_r.user[{s_axi_araddr[5:2], 2'h3}],
                   s_r.user[{s_axi_araddr[5:2], 2'h2}],
                   s_r.user[{s_axi_araddr[5:2], 2'h1}],
                   s_r.user[{s_axi_araddr[5:2], 2'h0}]};
      else
      begin
         case ({s_axi_araddr[7:2], 2'h0})
            dac_pkg::REG_ANT_CFG:
            begin
               rd_val[dac_pkg::F_AUTO] = s_r.auto_mode;
               rd_val[dac_pkg::F_CALC] = s_r.calc_seen;
               rd_val[dac_pkg::F_ORI_LSB +: 2] = s_r.orient;
               rd_val[dac_pkg::F_PRIM_LSB +: 2] = s_r.prim;
               rd_val[dac_pkg::F_SEC_LSB +: 2] = s_r.sec;
               rd_val[dac_pkg::F_PERM] = s_r.ant_perm;
            end
            dac_pkg::REG_OFS_X: rd_val = s_r.ofs_x;
            dac_pkg::REG_OFS_Y: rd_val = s_r.ofs_y;
            dac_pkg::REG_OFS_Z: rd_val = s_r.ofs_z;
            dac_pkg::REG_GIMBAL: rd_val = s_r.gimbal;
            dac_pkg::REG_GPIO_CFG: rd_val[dac_pkg::F_PERM] = s_r.gpio_perm;
            dac_pkg::REG_PKT_STAT:
            begin
               rd_val[dac_pkg::F_OK_LSB +: 8] = s_r.n_ok;
               rd_val[dac_pkg::F_BAD_LSB +: 8] = s_r.n_bad;
               rd_val[dac_pkg::F_BADID_LSB +: 8] = s_r.bad_id;
            end
            dac_pkg::REG_CTRL: rd_val[dac_pkg::F_EN] = s_r.en;
            default: rd_hit = 1'b0;
         endcase
      end
   end

   always_comb
   begin
      logic [7:0] el;
      logic good;
      logic [15:0] otype;
      logic [7:0] ori;
      el = exp_len(s_r.id);
      good = 1'b0;
      otype = 16'h0000;
      ori = 8'h00;
      s_nxt = s_r;
      s_nxt.upd = 1'b0;
      s_nxt.persist = 1'b0;

      // Register bus, write side; the counter clear comes before any commit
      // so that a packet counted in the same cycle is not lost.
      if (s_axi_awvalid && s_axi_awready)
      begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = s_axi_wdata;
         s_nxt.wstrb = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready)
         s_nxt.bvalid = 1'b0;
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
      begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = dac_pkg::RESP_OKAY;
         if ({s_r.awaddr[7:2], 2'h0} == dac_pkg::REG_CTRL)
         begin
            if (s_r.wstrb[0])
            begin
               s_nxt.en = s_r.wdata[dac_pkg::F_EN];
               if (s_r.wdata[dac_pkg::F_CLR])
               begin
                  s_nxt.n_ok = 8'h00;
                  s_nxt.n_bad = 8'h00;
                  s_nxt.bad_id = 8'h00;
               end
            end
         end
         else if ({s_r.awaddr[7:2], 2'h0} > dac_pkg::REG_CTRL &&
                  s_r.awaddr[7:6] != dac_pkg::USER_REGION)
            s_nxt.bresp = dac_pkg::RESP_SLVERR;
      end

      // Register bus, read side
      if (s_r.rvalid && s_axi_rready)
         s_nxt.rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = rd_val;
         s_nxt.rresp = rd_hit ? dac_pkg::RESP_OKAY : dac_pkg::RESP_SLVERR;
      end

      // Solver results replace stored offsets only while in automatic mode
      if (calc_valid && s_r.auto_mode)
      begin
         s_nxt.ofs_x = calc_x;
         s_nxt.ofs_y = calc_y;
         s_nxt.ofs_z = calc_z;
         s_nxt.calc_seen = 1'b1;
      end

      case (s_r.rx)
         DAC_IDLE:
         begin
            if (pkt_start && s_r.en)
            begin
               s_nxt.rx = DAC_RECV;
               s_nxt.id = pkt_id;
               s_nxt.len = pkt_len;
               s_nxt.cnt = 7'h00;
               s_nxt.ovf = 1'b0;
            end
         end
         DAC_RECV:
         begin
            if (pkt_byte_valid)
            begin
               if (s_r.cnt < 7'(dac_pkg::BUF_DEPTH))
               begin
                  s_nxt.stage[s_r.cnt] = pkt_byte;
                  s_nxt.cnt = s_r.cnt + 7'h01;
               end
               else
                  s_nxt.ovf = 1'b1;
            end
            if (pkt_end)
            begin
               s_nxt.rx = DAC_IDLE;
               good = (el != 8'h00) && (s_r.len == el) &&
                      (s_r.cnt == el[6:0]) && !s_r.ovf;
               otype = {s_r.stage[dac_pkg::B_OTYPE+1],
                        s_r.stage[dac_pkg::B_OTYPE]};
               ori = s_r.stage[dac_pkg::B_ORIENT];
               if (s_r.id == dac_pkg::ID_ANT)
               begin
                  // Unknown offset type, or an unknown orientation that
                  // would actually be used, is refused like a bad length
                  if (otype != dac_pkg::OTYPE_MANUAL &&
                      otype != dac_pkg::OTYPE_AUTO)
                     good = 1'b0;
                  if (otype == dac_pkg::OTYPE_AUTO && ori > dac_pkg::ORI_MAX)
                     good = 1'b0;
               end
               if (el != 8'h00 && !good)
               begin
                  s_nxt.n_bad = s_nxt.n_bad + 8'h01;
                  s_nxt.bad_id = s_r.id;
               end
               else if (good)
               begin
                  s_nxt.n_ok = s_nxt.n_ok + 8'h01;
                  s_nxt.upd = 1'b1;
                  s_nxt.persist_id = s_r.id;
                  case (s_r.id)
                     dac_pkg::ID_ANT:
                     begin
                        s_nxt.ant_perm = s_r.stage[dac_pkg::B_PERM] != 8'h00;
                        s_nxt.persist = s_nxt.ant_perm;
                        if (otype == dac_pkg::OTYPE_AUTO)
                        begin
                           // Manual values in the packet are dropped
                           s_nxt.auto_mode = 1'b1;
                           s_nxt.orient = ori[1:0];
                           {s_nxt.prim, s_nxt.sec} = pos_of(ori[1:0]);
                           // A solver result landing on this edge counts only if already in automatic mode
                           s_nxt.calc_seen = calc_valid && s_r.auto_mode;
                        end
                        else
                        begin
                           // Orientation byte is dropped
                           s_nxt.auto_mode = 1'b0;
                           s_nxt.ofs_x = get32(s_r.stage, dac_pkg::B_OFS_X);
                           s_nxt.ofs_y = get32(s_r.stage, dac_pkg::B_OFS_Y);
                           s_nxt.ofs_z = get32(s_r.stage, dac_pkg::B_OFS_Z);
                        end
                     end
                     dac_pkg::ID_USER:
                        s_nxt.user = s_r.stage[dac_pkg::USER_BYTES-1:0];
                     default:
                     begin
                        s_nxt.gpio_perm = s_r.stage[dac_pkg::B_PERM] != 8'h00;
                        s_nxt.persist = s_nxt.gpio_perm;
                        s_nxt.gimbal = get32(s_r.stage,
                                             dac_pkg::B_GIMBAL);
                     end
                  endcase
               end
            end
         end
         default: s_nxt.rx = DAC_IDLE;
      endcase

      // Readback stream of a stored packet payload
      case (s_r.tx)
         DAC_TX_IDLE:
         begin
            if (rd_req && exp_len(rd_id) != 8'h00)
            begin
               s_nxt.tx = DAC_TX_SEND;
               s_nxt.tx_id = rd_id;
               s_nxt.tx_idx = 7'h00;
               s_nxt.tx_len = 7'(exp_len(rd_id));
               s_nxt.tx_byte = 8'h00;
            end
         end
         DAC_TX_SEND:
         begin
            s_nxt.tx_byte = tx_at(s_r, s_r.tx_idx);
            if (rply_ready)
            begin
               if (s_r.tx_idx + 7'h01 == s_r.tx_len)
                  s_nxt.tx = DAC_TX_IDLE;
               s_nxt.tx_idx = s_r.tx_idx + 7'h01;
               s_nxt.tx_byte = tx_at(s_r, s_r.tx_idx + 7'h01);
            end
         end
         default: s_nxt.tx = DAC_TX_IDLE;
      endcase
      if (s_r.tx == DAC_TX_IDLE && s_nxt.tx == DAC_TX_SEND)
         s_nxt.tx_byte = tx_at(s_nxt, 7'h00);
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_r <= '0;
         s_r.auto_mode <= 1'b1;
         s_r.orient <= dac_pkg::ORI_PF_SR;
         s_r.prim <= dac_pkg::POS_FRONT;
         s_r.sec <= dac_pkg::POS_REAR;
         s_r.en <= dac_pkg::CTRL_EN_RST;
      end
      else
         s_r <= s_nxt;
   end

   assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
   assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = !s_r.rvalid;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign rd_busy = s_r.tx != DAC_TX_IDLE;
   assign rply_valid = s_r.tx == DAC_TX_SEND;
   assign rply_byte = s_r.tx_byte;
   assign rply_last = (s_r.tx == DAC_TX_SEND) &&
                      (s_r.tx_idx + 7'h01 == s_r.tx_len);
   assign auto_mode = s_r.auto_mode;
   assign prim_pos = s_r.prim;
   assign sec_pos = s_r.sec;
   assign ofs_x = s_r.ofs_x;
   assign ofs_y = s_r.ofs_y;
   assign ofs_z = s_r.ofs_z;
   assign gimbal_scale = s_r.gimbal;
   assign cfg_update = s_r.upd;
   assign persist_req = s_r.persist;
   assign persist_id = s_r.persist_id;
endmodule
`default_nettype wire

// file: dv/dac_decoder_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dac_decoder_monitor (
   input wire logic clk,
   input wire logic nrst,
   input wire logic calc_valid,
   input wire logic [31:0] calc_x,
   input wire logic auto_mode,
   input wire logic [1:0] prim_pos,
   input wire logic [1:0] sec_pos,
   input wire logic [31:0] ofs_x,
   input wire logic [31:0] gimbal_scale,
   input wire logic cfg_update,
   input wire logic persist_req,
   input wire logic [7:0] persist_id,
   input wire logic rply_valid,
   input wire logic rply_ready,
   input wire logic rply_last
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   a_reset_dflt: assert property (
      $rose(nrst) |-> auto_mode && prim_pos == dac_pkg::POS_FRONT &&
      sec_pos == dac_pkg::POS_REAR)
      else $error("antenna defaults wrong after reset");
   // Every legal orientation places the two antennas on opposite sides
   a_orient_pair: assert property (
      sec_pos == (prim_pos ^ 2'h1))
      else $error("antenna positions not a legal pair");
   a_manual_orient: assert property (
      cfg_update && !auto_mode |-> $stable(prim_pos) && $stable(sec_pos))
      else $error("manual packet changed orientation");
   a_auto_keeps: assert property (
      cfg_update && auto_mode && !$past(calc_valid) |-> $stable(ofs_x))
      else $error("auto packet loaded manual offset");
   a_calc_load: assert property (
      calc_valid && auto_mode |=>
      ofs_x == $past(calc_x) || cfg_update && !auto_mode)
      else $error("computed offset not stored");
   a_calc_manual: assert property (
      calc_valid && !auto_mode |=> $stable(ofs_x) || cfg_update)
      else $error("computed offset overwrote manual offset");
   a_ofs_cause: assert property (
      $changed(ofs_x) |-> cfg_update || $past(calc_valid))
      else $error("offset changed without a cause");
   a_gimbal_cause: assert property (
      $changed(gimbal_scale) |-> cfg_update &&
      persist_id == dac_pkg::ID_GPIO)
      else $error("gimbal scale changed without gpio packet");
   a_persist_src: assert property (
      persist_req |-> cfg_update && persist_id != dac_pkg::ID_USER)
      else $error("persist request from user content");
   c_auto: cover property (cfg_update && auto_mode);
   c_manual: cover property (cfg_update && !auto_mode);
   c_persist: cover property (persist_req);
   c_reply: cover property (rply_valid && rply_ready && rply_last);
endmodule
bind dac_decoder dac_decoder_monitor mon (.*);
`default_nettype wire

// file: dv/dac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dac_host_model (
   input wire logic clk,
   output logic pkt_start,
   output logic [7:0] pkt_id,
   output logic [7:0] pkt_len,
   output logic pkt_byte_valid,
   output logic [7:0] pkt_byte,
   output logic pkt_end,
   output logic rd_req,
   output logic [7:0] rd_id,
   input wire logic rd_busy,
   input wire logic rply_valid,
   input wire logic [7:0] rply_byte,
   input wire logic rply_last,
   output logic rply_ready
);
   logic [7:0] rx [0:64];
   initial
   begin
      pkt_start = 1'b0;
      pkt_id = 8'h00;
      pkt_len = 8'h00;
      pkt_byte_valid = 1'b0;
      pkt_byte = 8'h00;
      pkt_end = 1'b0;
      rd_req = 1'b0;
      rd_id = 8'h00;
      rply_ready = 1'b0;
   end
   // Idle data lines carry the inverse so stale bytes are never reused
   task automatic send(input logic [7:0] id, input logic [7:0] len,
      input int n, input logic [7:0] b [0:64]);
      pkt_start <= 1'b1;
      pkt_id <= id;
      pkt_len <= len;
      @(posedge clk);
      pkt_start <= 1'b0;
      pkt_id <= ~id;
      for (int i = 0; i < n; i++)
      begin
         pkt_byte_valid <= 1'b1;
         pkt_byte <= b[i];
         @(posedge clk);
         if ($urandom_range(3) == 0)
         begin
            pkt_byte_valid <= 1'b0;
            pkt_byte <= ~pkt_byte;
            @(posedge clk);
         end
      end
      pkt_byte_valid <= 1'b0;
      pkt_byte <= ~pkt_byte;
      pkt_end <= 1'b1;
      @(posedge clk);
      pkt_end <= 1'b0;
      @(posedge clk);
   endtask
   task automatic fetch(input logic [7:0] id, output int got);
      got = 0;
      for (int w = 0; w < 8 && rd_busy; w++)
         @(posedge clk);
      rd_req <= 1'b1;
      rd_id <= id;
      @(posedge clk);
      rd_req <= 1'b0;
      rd_id <= ~id;
      for (int w = 0; w < 400; w++)
      begin
         rply_ready <= 1'($urandom_range(1));
         @(posedge clk);
         if (rply_valid && rply_ready)
         begin
            rx[got] = rply_byte;
            got++;
            if (rply_last) break;
         end
      end
      rply_ready <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
`define CHK(g, e) \
   begin \
      tests_run++; \
      if ((g) !== (e)) \
      begin \
         err_count++; \
         $display("ERROR t=%0t got %h exp %h", $time, g, e); \
      end \
   end
   logic clk, nrst, pkt_start, pkt_byte_valid, pkt_end, calc_valid;
   logic rd_req, rd_busy, rply_valid, rply_last, rply_ready;
   logic auto_mode, cfg_update, persist_req;
   logic [7:0] pkt_id, pkt_len, pkt_byte, rd_id, rply_byte, persist_id;
   logic [1:0] prim_pos, sec_pos, s_axi_bresp, s_axi_rresp;
   logic [31:0] calc_x, calc_y, calc_z, ofs_x, ofs_y, ofs_z, gimbal_scale;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, x, y, z, rdat;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [1:0] rsp;
   logic [7:0] bad;
   logic [7:0] b [0:64];
   int err_count, tests_run, acc, rej, got;
   dac_decoder dut (.*);
   dac_host_model host (.*);
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic test_done;
      $display("Checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic hang;
      err_count++;
      test_done();
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int w = 0; w <= 50; w++)
      begin
         @(posedge clk);
         if (w == 50) hang();
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic axi_rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int w = 0; w <= 50; w++)
      begin
         @(posedge clk);
         if (w == 50) hang();
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask
   function automatic logic [3:0] pos_of(input logic [7:0] o);
      case (o)
         8'h00: return {dac_pkg::POS_FRONT, dac_pkg::POS_REAR};
         8'h01: return {dac_pkg::POS_REAR, dac_pkg::POS_FRONT};
         8'h02: return {dac_pkg::POS_RIGHT, dac_pkg::POS_LEFT};
         default: return {dac_pkg::POS_LEFT, dac_pkg::POS_RIGHT};
      endcase
   endfunction
   task automatic fill_ant(input logic [15:0] t, input logic [7:0] o);
      b[0] = 8'h01;
      {b[2], b[1]} = t;
      b[3] = o;
      b[4] = 8'h00;
      {b[8], b[7], b[6], b[5]} = x;
      {b[12], b[11], b[10], b[9]} = y;
      {b[16], b[15], b[14], b[13]} = z;
   endtask
   task automatic calc_pulse;
      calc_x <= x;
      calc_y <= y;
      calc_z <= z;
      calc_valid <= 1'b1;
      @(posedge clk);
      calc_valid <= 1'b0;
      @(posedge clk);
   endtask
   initial
   begin
      {nrst, calc_valid, calc_x, calc_y, calc_z} = '0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      {err_count, tests_run, acc, rej} = '0;
      void'($urandom(74));
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      `CHK(auto_mode, 1'b1)
      `CHK({prim_pos, sec_pos}, pos_of(8'h00))
      axi_rd(dac_pkg::REG_ANT_CFG);
      `CHK(rdat, 32'h0000_4001)
      axi_rd(8'h20);
      `CHK(rsp, dac_pkg::RESP_SLVERR)
      // Selector 4 is out of range and must leave selector 3 in place
      for (int o = 0; o < 5; o++)
      begin
         {x, y, z} = {$urandom, $urandom, $urandom};
         fill_ant(dac_pkg::OTYPE_AUTO, 8'(o));
         host.send(dac_pkg::ID_ANT, dac_pkg::LEN_ANT, 17, b);
         acc += (o < 4);
         rej += (o == 4);
         `CHK({prim_pos, sec_pos}, pos_of(8'(o < 4 ? o : 3)))
         `CHK(ofs_x, 32'h0)
      end
      bad = dac_pkg::ID_ANT;
      {x, y, z} = {$urandom, $urandom, $urandom};
      calc_pulse();
      `CHK({ofs_x, ofs_y, ofs_z}, {x, y, z})
      axi_rd(dac_pkg::REG_ANT_CFG);
      `CHK(rdat, 32'h0001_b303)
      host.fetch(dac_pkg::ID_ANT, got);
      `CHK(got, 17)
      `CHK({host.rx[8], host.rx[7], host.rx[6], host.rx[5]}, x)
      `CHK(host.rx[1], 8'h01)
      {x, y, z} = {$urandom, $urandom, $urandom};
      fill_ant(dac_pkg::OTYPE_MANUAL, 8'h01);
      host.send(dac_pkg::ID_ANT, dac_pkg::LEN_ANT, 17, b);
      acc++;
      `CHK(auto_mode, 1'b0)
      `CHK({prim_pos, sec_pos}, pos_of(8'h03))
      `CHK({ofs_x, ofs_y, ofs_z}, {x, y, z})
      x = ~x;
      calc_pulse();
      `CHK(ofs_x, ~x)
      fill_ant(dac_pkg::OTYPE_AUTO, 8'h00);
      host.send(dac_pkg::ID_ANT, 8'h10, 16, b);
      host.send(dac_pkg::ID_ANT, dac_pkg::LEN_ANT, 16, b);
      host.send(8'h50, 8'h01, 1, b);
      fill_ant(16'h0002, 8'h00);
      host.send(dac_pkg::ID_ANT, dac_pkg::LEN_ANT, 17, b);
      rej += 3;
      `CHK(auto_mode, 1'b0)
      for (int i = 0; i < 65; i++)
         b[i] = 8'($urandom);
      host.send(dac_pkg::ID_USER, dac_pkg::LEN_USER, 64, b);
      acc++;
      `CHK(auto_mode, 1'b0)
      host.fetch(dac_pkg::ID_USER, got);
      `CHK(got, 64)
      for (int i = 0; i < 64; i++)
         `CHK(host.rx[i], b[i])
      axi_rd(8'h7c);
      `CHK(rdat, {b[63], b[62], b[61], b[60]})
      x = $urandom;
      for (int i = 0; i < 65; i++)
         b[i] = 8'h00;
      {b[4], b[3], b[2], b[1]} = x;
      host.send(dac_pkg::ID_GPIO, dac_pkg::LEN_GPIO, 65, b);
      acc++;
      `CHK(gimbal_scale, x)
      host.fetch(dac_pkg::ID_GPIO, got);
      `CHK(got, 65)
      `CHK({host.rx[4], host.rx[3], host.rx[2], host.rx[1]}, x)
      `CHK(host.rx[64], 8'h00)
      axi_wr(dac_pkg::REG_CTRL, 32'h0);
      fill_ant(dac_pkg::OTYPE_AUTO, 8'h00);
      host.send(dac_pkg::ID_ANT, dac_pkg::LEN_ANT, 17, b);
      `CHK(auto_mode, 1'b0)
      axi_wr(dac_pkg::REG_CTRL, 32'h1);
      `CHK(rsp, dac_pkg::RESP_OKAY)
      axi_rd(dac_pkg::REG_PKT_STAT);
      `CHK(rdat, {8'h00, bad, 8'(rej), 8'(acc)})
      axi_wr(dac_pkg::REG_CTRL, 32'h3);
      axi_rd(dac_pkg::REG_PKT_STAT);
      `CHK(rdat, 32'h0)
      test_done();
   end
endmodule
`default_nettype wire
